// [design/rtc_core.sv]
// time, calendar and alarm core of the rtc with a classic wishbone slave
// How it works
// - seconds count BCD 00 to 59, then wrap to 00, once per second.
// - writing seconds clears the sub-second divider so the next step is a second away.
// - minutes count BCD 00 to 59 and wrap to 00.
// - hours count 24-hour BCD 00 to 23 and wrap to 00.
// - all time and calendar values except the one-hot weekday are packed BCD, tens in upper nibble.
// - weekday is one-hot in bits 0 to 6, shifting left daily, 40h back to 01h.
// - Sunday is 01h up to Saturday 40h; bit 7 always zero.
// - calendar steps date, month and year correctly from 2001 to 2099.
// - date wraps after 31, 30 or 28 depending on the month.
// - a year value divisible by four lets February reach 29.
// - month steps 1 to 12 and wraps to 1 when the date wraps.
// - year holds two BCD digits, 00 to 99, then wraps to 00.
// - scratch byte at 7 stores any value with no other effect.
// - alarms: minute at 8, hour at 9, weekday or date at A, mask bit 7.
// - alarm match sets the alarm flag and drives the interrupt pin low.
// - fixed-zero bits of time registers ignore writes and read zero.
// - free storage bits in alarm registers are plain storage, not compared.
// - select 1 compares the A alarm with date, 0 with the weekday.
// - interrupt pin goes low only while the alarm interrupt enable is 1.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_params.svh"

module rtc_core
  import rtc_pkg::*;
#(
  parameter int CLK_HZ = `CLK_HZ,
  parameter int XTAL_HZ = `XTAL_HZ,
  parameter int XTAL_DIV = `SECOND_S * `XTAL_HZ
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_n_o
);

  localparam int ACC_W = $clog2(CLK_HZ) + 1;
  localparam int DIV_W = $clog2(XTAL_DIV);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(XTAL_HZ);
  localparam logic [ACC_W-1:0] ACC_TOP = ACC_W'(CLK_HZ);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(XTAL_DIV - 1);

  clock_state_type now;
  logic [7:0] scratch_byte;
  logic [7:0] m_alarm_reg;
  logic [7:0] hour_alarm_reg;
  logic [7:0] date_alarm_reg;
  logic [7:0] weekday_alarm_reg;
  logic weekday_or_date_select;
  logic alarm_hit_flag;
  logic alarm_int_enable;

  logic bus_req;
  logic wr_en;
  logic mapped;
  logic [3:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;

  logic [ACC_W-1:0] phase;
  logic [ACC_W-1:0] phase_sum;
  logic xtal_en;
  logic [DIV_W-1:0] sub_count;
  logic sec_tick;
  logic pending;
  logic step;
  logic s_write;

  logic s_wrap;
  logic m_wrap;
  logic h_wrap;
  logic date_wrap;
  logic month_wrap;
  logic leap;
  logic [7:0] month_len;

  logic m_ok;
  logic h_ok;
  logic dw_ok;
  logic match_now;
  logic match_q;
  logic alarm_event;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic wr_to(input logic [3:0] k);
    wr_to = wr_en && mapped && (idx == k);
  endfunction

  // bus decode, one aligned word per register
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[5:2];
  assign mapped = (wb_adr_i[7:6] == 2'b00) && (wb_adr_i[1:0] == 2'b00);
  assign wdata = wb_dat_i[7:0];
  assign s_write = wr_en && mapped && (idx == `S_COUNT_IDX);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (mapped) begin
      unique case (idx)
        `S_COUNT_IDX: rdata = now.s_count_reg;
        `M_COUNT_IDX: rdata = now.m_count_reg;
        `HOUR_IDX: rdata = now.hour_count_reg;
        `WEEKDAY_IDX: rdata = {1'b0, now.weekday_onehot_reg};
        `DATE_IDX: rdata = now.date_count_reg;
        `MONTH_IDX: rdata = now.month_count_reg;
        `YEAR_IDX: rdata = now.year_count_reg;
        `SCRATCH_IDX: rdata = scratch_byte;
        `M_ALARM_IDX: rdata = m_alarm_reg;
        `HOUR_ALARM_IDX: rdata = hour_alarm_reg;
        `DW_ALARM_IDX: rdata = date_alarm_reg;
        `EXT_IDX: rdata = {1'b0, weekday_or_date_select, 6'h00};
        `FLAG_IDX: rdata = {4'h0, alarm_hit_flag, 3'h0};
        `CTRL_IDX: rdata = {4'h0, alarm_int_enable, 3'h0};
        default: rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rdata};
    end
  end

  // crystal timebase
  // fractional accumulator gives 32.768 kHz enables from clk_i
  assign phase_sum = phase + ACC_STEP;
  assign xtal_en = phase_sum >= ACC_TOP;
  assign sec_tick = xtal_en && (sub_count == DIV_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i || s_write) begin
      phase <= '0;
      sub_count <= '0;
    end else if (xtal_en) begin
      phase <= phase_sum - ACC_TOP;
      sub_count <= (sub_count == DIV_LAST) ? '0 : sub_count + 1'b1;
    end else begin
      phase <= phase_sum;
    end
  end

  // a tick during a bus write waits one cycle instead of racing it
  always_ff @(posedge clk_i) begin
    if (rst_i || s_write) begin
      pending <= 1'b0;
    end else if (sec_tick) begin
      pending <= 1'b1;
    end else if (step) begin
      pending <= 1'b0;
    end
  end

  assign step = pending & ~wr_en;

  // leap when the BCD year is divisible by four
  assign leap = !now.year_count_reg[0] &&
                (now.year_count_reg[1] == now.year_count_reg[4]);

  always_comb begin
    unique case (now.month_count_reg)
      `FEBRUARY: month_len = leap ? `LEN_29 : `LEN_28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = `LEN_30;
      default: month_len = `LEN_31;
    endcase
  end

  assign s_wrap = step && (now.s_count_reg == `S_LAST);
  assign m_wrap = s_wrap && (now.m_count_reg == `M_LAST);
  assign h_wrap = m_wrap && (now.hour_count_reg == `HOUR_LAST);
  assign date_wrap = h_wrap && (now.date_count_reg == month_len);
  assign month_wrap = date_wrap && (now.month_count_reg == `MONTH_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      now.s_count_reg <= 8'h00;
      now.m_count_reg <= 8'h00;
      now.hour_count_reg <= 8'h00;
      now.weekday_onehot_reg <= `WEEKDAY_FIRST;
      now.date_count_reg <= `DATE_FIRST;
      now.month_count_reg <= `MONTH_FIRST;
      now.year_count_reg <= `RESET_YEAR;
    end else begin
      if (s_write) begin
        now.s_count_reg <= wdata & `S_COUNT_MASK;
      end else if (step) begin
        now.s_count_reg <= s_wrap ? 8'h00 : bcd_inc(now.s_count_reg);
      end
      if (wr_to(`M_COUNT_IDX)) begin
        now.m_count_reg <= wdata & `M_COUNT_MASK;
      end else if (s_wrap) begin
        now.m_count_reg <= m_wrap ? 8'h00 : bcd_inc(now.m_count_reg);
      end
      if (wr_to(`HOUR_IDX)) begin
        now.hour_count_reg <= wdata & `HOUR_MASK;
      end else if (m_wrap) begin
        now.hour_count_reg <= h_wrap ? 8'h00 : bcd_inc(now.hour_count_reg);
      end
      if (wr_to(`WEEKDAY_IDX)) begin
        now.weekday_onehot_reg <= wdata[6:0];
      end else if (h_wrap) begin
        now.weekday_onehot_reg <= (now.weekday_onehot_reg == `WEEKDAY_LAST) ?
                                  `WEEKDAY_FIRST : {now.weekday_onehot_reg[5:0], 1'b0};
      end
      if (wr_to(`DATE_IDX)) begin
        now.date_count_reg <= wdata & `DATE_MASK;
      end else if (h_wrap) begin
        now.date_count_reg <= date_wrap ? `DATE_FIRST : bcd_inc(now.date_count_reg);
      end
      if (wr_to(`MONTH_IDX)) begin
        now.month_count_reg <= wdata & `MONTH_MASK;
      end else if (date_wrap) begin
        now.month_count_reg <= month_wrap ? `MONTH_FIRST : bcd_inc(now.month_count_reg);
      end
      if (wr_to(`YEAR_IDX)) begin
        now.year_count_reg <= wdata;
      end else if (month_wrap) begin
        now.year_count_reg <= (now.year_count_reg == `YEAR_LAST) ?
                              8'h00 : bcd_inc(now.year_count_reg);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scratch_byte <= 8'h00;
      m_alarm_reg <= `ALARM_RESET;
      hour_alarm_reg <= `ALARM_RESET;
      date_alarm_reg <= `ALARM_RESET;
      weekday_or_date_select <= 1'b0;
      alarm_int_enable <= 1'b0;
    end else begin
      if (wr_to(`SCRATCH_IDX)) begin
        scratch_byte <= wdata;
      end
      if (wr_to(`M_ALARM_IDX)) begin
        m_alarm_reg <= wdata;
      end
      if (wr_to(`HOUR_ALARM_IDX)) begin
        hour_alarm_reg <= wdata;
      end
      if (wr_to(`DW_ALARM_IDX)) begin
        date_alarm_reg <= wdata;
      end
      if (wr_to(`EXT_IDX)) begin
        weekday_or_date_select <= wdata[`SELECT_BIT];
      end
      if (wr_to(`CTRL_IDX)) begin
        alarm_int_enable <= wdata[`INT_EN_BIT];
      end
    end
  end

  // the A slot holds either the weekday or the date alarm
  assign weekday_alarm_reg = date_alarm_reg;

  assign m_ok = m_alarm_reg[`MASK_BIT] || (m_alarm_reg[6:0] == now.m_count_reg[6:0]);
  assign h_ok = hour_alarm_reg[`MASK_BIT] ||
                (hour_alarm_reg[5:0] == now.hour_count_reg[5:0]);
  assign dw_ok = weekday_alarm_reg[`MASK_BIT] ||
                 (weekday_or_date_select ?
                  (date_alarm_reg[5:0] == now.date_count_reg[5:0]) :
                  |(weekday_alarm_reg[6:0] & now.weekday_onehot_reg));
  assign match_now = m_ok && h_ok && dw_ok;
  assign alarm_event = match_now && !match_q;

  // starts high so a reset with all fields masked raises no event
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_q <= 1'b1;
    end else begin
      match_q <= match_now;
    end
  end

  // alarm flag, a new event beats a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_hit_flag <= 1'b0;
    end else if (alarm_event) begin
      alarm_hit_flag <= 1'b1;
    end else if (wr_to(`FLAG_IDX) && !wdata[`HIT_BIT]) begin
      alarm_hit_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= !(alarm_hit_flag && alarm_int_enable);
    end
  end

  s_wrap_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_wrap && !s_write |=> now.s_count_reg == 8'h00)
    else $error("seconds did not wrap to 00");

  s_step_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    step && !s_wrap && !s_write |=> now.s_count_reg == bcd_inc($past(now.s_count_reg)))
    else $error("seconds did not step by one");

  div_clear_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_write |=> sub_count == '0 && !pending)
    else $error("divider not cleared by seconds write");

  m_wrap_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    m_wrap && !wr_en |=> now.m_count_reg == 8'h00 && now.s_count_reg == 8'h00)
    else $error("minutes did not wrap with seconds");

  hour_wrap_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    h_wrap && !wr_en |=> now.hour_count_reg == 8'h00)
    else $error("hours did not wrap after 23");

  weekday_rot_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    h_wrap && !wr_en && now.weekday_onehot_reg == 7'h40 |=> now.weekday_onehot_reg == 7'h01)
    else $error("weekday did not return to 01h");

  feb_len_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    h_wrap && !wr_en && now.month_count_reg == 8'h02 && now.date_count_reg == 8'h28
    |=> now.date_count_reg == ($past(leap) ? 8'h29 : 8'h01))
    else $error("february end wrong for leap state");

  month_wrap_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    month_wrap && !wr_en |=> now.month_count_reg == 8'h01 && now.date_count_reg == 8'h01)
    else $error("new year did not restart january 01");

  zero_bits_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    now.hour_count_reg[7:6] == 2'b00 && now.date_count_reg[7:6] == 2'b00 &&
    now.month_count_reg[7:5] == 3'b000 && !now.s_count_reg[7])
    else $error("fixed-zero bit set");

  alarm_set_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    alarm_event |=> alarm_hit_flag ##1 (irq_n_o == !alarm_int_enable))
    else $error("alarm event not flagged on pin");

  irq_gate_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !irq_n_o |-> $past(alarm_hit_flag) && $past(alarm_int_enable))
    else $error("interrupt low without enabled flag");

endmodule

`default_nettype wire

// [design/rtc_params.svh]
// register map, field masks, reset values and timing counts of the rtc core
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

`define S_COUNT_IDX 4'h0
`define M_COUNT_IDX 4'h1
`define HOUR_IDX 4'h2
`define WEEKDAY_IDX 4'h3
`define DATE_IDX 4'h4
`define MONTH_IDX 4'h5
`define YEAR_IDX 4'h6
`define SCRATCH_IDX 4'h7
`define M_ALARM_IDX 4'h8
`define HOUR_ALARM_IDX 4'h9
`define DW_ALARM_IDX 4'ha
`define EXT_IDX 4'hd
`define FLAG_IDX 4'he
`define CTRL_IDX 4'hf

`define S_COUNT_MASK 8'h7f
`define M_COUNT_MASK 8'h7f
`define HOUR_MASK 8'h3f
`define DATE_MASK 8'h3f
`define MONTH_MASK 8'h1f
`define SELECT_BIT 6
`define HIT_BIT 3
`define INT_EN_BIT 3
`define MASK_BIT 7

`define S_LAST 8'h59
`define M_LAST 8'h59
`define HOUR_LAST 8'h23
`define WEEKDAY_FIRST 7'h01
`define WEEKDAY_LAST 7'h40
`define DATE_FIRST 8'h01
`define MONTH_FIRST 8'h01
`define MONTH_LAST 8'h12
`define YEAR_LAST 8'h99
`define FEBRUARY 8'h02
`define LEN_31 8'h31
`define LEN_30 8'h30
`define LEN_29 8'h29
`define LEN_28 8'h28

`define RESET_YEAR 8'h01
`define ALARM_RESET 8'h80

`define CLK_HZ 10000000
`define XTAL_HZ 32768
`define SECOND_S 1

`endif

// [design/rtc_pkg.sv]
// types shared by the rtc core
package rtc_pkg;
  typedef struct packed {
    logic [7:0] year_count_reg;
    logic [7:0] month_count_reg;
    logic [7:0] date_count_reg;
    logic [6:0] weekday_onehot_reg;
    logic [7:0] hour_count_reg;
    logic [7:0] m_count_reg;
    logic [7:0] s_count_reg;
  } clock_state_type;
endpackage

// [testbench/rtc_host_model.sv]
// host-side classic wishbone master model for the rtc core
`timescale 1ns/1ns
`default_nettype none
module rtc_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // one single cycle; request held until ack is sampled, bounded wait
  task automatic xfer(input logic w, input logic [3:0] idx, input logic [7:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 32'h0;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {2'b00, idx, 2'b00};
    sel_o <= 4'h1;
    dat_o <= {24'h0, d};
    for (n = 0; n < 50 && ok == 1'b0; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        q = dat_i;
      end
    end
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    // released lines stop showing the last value
    adr_o <= ~adr_o;
    dat_o <= ~{24'h0, d};
  endtask
endmodule
`default_nettype wire

// [testbench/rtc_core_tb_top.sv]
// self-checking bench for the rtc time, calendar and alarm core
`timescale 1ns/1ns
`default_nettype none
module rtc_core_tb_top;
  logic clk_i;
  logic rst_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_n_o;
  logic [31:0] rdat;
  logic ok;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] rst_val [16] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00,
                               8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] r_mo [6] = '{8'h01, 8'h04, 8'h02, 8'h02, 8'h12, 8'h06};
  logic [7:0] r_dt [6] = '{8'h31, 8'h30, 8'h28, 8'h28, 8'h31, 8'h15};
  logic [7:0] r_yr [6] = '{8'h03, 8'h03, 8'h03, 8'h04, 8'h99, 8'h03};
  logic [7:0] n_dt [6] = '{8'h01, 8'h01, 8'h01, 8'h29, 8'h01, 8'h16};
  logic [7:0] n_mo [6] = '{8'h02, 8'h05, 8'h03, 8'h02, 8'h01, 8'h06};
  logic [7:0] n_yr [6] = '{8'h03, 8'h03, 8'h03, 8'h04, 8'h00, 8'h03};

  // a second every 16 clocks
  rtc_core #(.CLK_HZ(10000000), .XTAL_HZ(2500000), .XTAL_DIV(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_n_o(irq_n_o)
  );

  rtc_host_model i_host (
    .clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
    .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
    i_host.xfer(w, idx, d, rdat, ok);
    if (ok !== 1'b1) begin
      $display("Error at %0t ns: ack %h expected %h", $time, ok, 1'b1);
      bad_count++;
      end_of_test;
    end
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [3:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rdat, {24'h0, exp});
  endtask

  // pin sampled mid-cycle, away from the edge that launches it
  task automatic pin_check(input logic exp);
    @(negedge clk_i);
    check({31'h0, irq_n_o}, {31'h0, exp});
  endtask

  task automatic reset_values;
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], rst_val[i]);
    end
    pin_check(1'b1);
  endtask

  task automatic storage_bits;
    wr(4'h7, 8'hff);
    rd(4'h7, 8'hff);
    wr(4'h7, 8'h00);
    rd(4'h7, 8'h00);
    wr(4'h7, 8'ha5);
    rd(4'h7, 8'ha5);
    wr(4'h2, 8'hd9);
    rd(4'h2, 8'h19);
    wr(4'h5, 8'he9);
    rd(4'h5, 8'h09);
  endtask

  task automatic roll(input int i);
    logic [7:0] wd;
    logic [7:0] nwd;
    wd = 8'h40 >> i;
    nwd = (wd == 8'h40) ? 8'h01 : (wd << 1);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h23);
    wr(4'h1, 8'h59);
    wr(4'h3, wd);
    wr(4'h6, r_yr[i]);
    wr(4'h5, r_mo[i]);
    wr(4'h4, r_dt[i]);
    wr(4'h0, 8'h59);
    // divider cleared: no step for the next 16 clocks
    repeat (10) @(posedge clk_i);
    rd(4'h0, 8'h59);
    repeat (4) @(posedge clk_i);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'h3, nwd);
    rd(4'h4, n_dt[i]);
    rd(4'h5, n_mo[i]);
    rd(4'h6, n_yr[i]);
  endtask

  task automatic alarm(input logic [7:0] ah, input logic sel, input logic [7:0] aa,
                       input logic en, input logic hit);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'h14);
    wr(4'h2, 8'h10);
    wr(4'h4, 8'h01);
    wr(4'h3, 8'h01);
    wr(4'h8, 8'h15);
    wr(4'h9, ah);
    wr(4'ha, aa);
    wr(4'hd, {1'b0, sel, 6'h00});
    wr(4'hf, {4'h0, en, 3'h0});
    wr(4'he, 8'h00);
    wr(4'h0, 8'h59);
    rd(4'h9, ah);
    pin_check(1'b1);
    repeat (20) @(posedge clk_i);
    pin_check(~(hit & en));
    rd(4'he, {4'h0, hit, 3'h0});
    wr(4'he, 8'h00);
    repeat (2) @(posedge clk_i);
    pin_check(1'b1);
    rd(4'he, 8'h00);
  endtask

  initial begin
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    storage_bits();
    for (int i = 0; i < 6; i++) begin
      roll(i);
    end
    alarm(8'h50, 1'b1, 8'h41, 1'b1, 1'b1);
    alarm(8'h85, 1'b0, 8'h02, 1'b1, 1'b0);
    alarm(8'h85, 1'b0, 8'h01, 1'b0, 1'b1);
    alarm(8'h09, 1'b1, 8'h81, 1'b1, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
